/* File: hw/trap_stack_pkg.sv */
// Constants and types shared by the trap privilege stack block
package trap_stack_pkg;
  localparam int DW = 64;
  localparam int AW = 8;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_RSV = 2'h2;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam logic [AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [AW-1:0] OFS_STATUSH = 8'h08;
  localparam logic [AW-1:0] OFS_NMI_STATUS = 8'h10;
  localparam logic [AW-1:0] OFS_NMI_EPC = 8'h18;
  localparam logic [AW-1:0] OFS_NMI_CAUSE = 8'h20;
  localparam logic [AW-1:0] OFS_M_EPC = 8'h28;
  localparam logic [AW-1:0] OFS_M_CAUSE = 8'h30;
  localparam logic [AW-1:0] OFS_HART_STATE = 8'h38;
  localparam logic [AW-1:0] OFS_VS_STATUS = 8'h40;
  localparam int BIT_SGIE = 1;
  localparam int BIT_MGIE = 3;
  localparam int BIT_SPREV_IE = 5;
  localparam int BIT_MPREV_IE = 7;
  localparam int BIT_SPREV_PRIV = 8;
  localparam int BIT_MPREV_PRIV = 11;
  localparam int BIT_LS_PRIV = 17;
  localparam int BIT_STRAP_OFF = 24;
  localparam int BIT_MPREV_VIRT = 39;
  localparam int BIT_MTRAP_OFF = 42;
  localparam int BITH_MPREV_VIRT = 7;
  localparam int BITH_MTRAP_OFF = 10;
  localparam int BITN_NMI_ON = 3;
  localparam int BITN_PREV_VIRT = 7;
  localparam int BITN_PREV_PRIV = 11;
  localparam int BITS_PRIV = 0;
  localparam int BITS_VIRT = 2;
  localparam int BITS_CRIT = 3;
  localparam logic RST_MTRAP_OFF = 1'b1;
  localparam logic RST_NMI_ON = 1'b0;
  typedef enum logic {HART_RUN, HART_CRIT} hart_e;
  typedef enum logic [1:0] {REDIR_M, REDIR_S, REDIR_NMI, REDIR_RET} redir_e;
endpackage : trap_stack_pkg

/* File: hw/irq_gate_if.sv */
// Carrier between the trap stack and its interrupt enable gate
`timescale 1ns/1ns
interface irq_gate_if;
  logic clk;
  logic [1:0] privMode;
  logic mGie;
  logic sGie;
  logic halted;
  logic enM;
  logic enS;
  modport stack (output clk, output privMode, output mGie, output sGie, output halted,
                 input enM, input enS);
  modport gate (input clk, input privMode, input mGie, input sGie, input halted,
                output enM, output enS);
endinterface : irq_gate_if

/* File: hw/irq_gate.sv */
// Global interrupt enable per target mode, masked by current privilege
`timescale 1ns/1ns
module irq_gate
  import trap_stack_pkg::*;
(
  // Link to the trap stack
  irq_gate_if.gate g
);
  always_comb begin
    g.enM = 1'b0;
    g.enS = 1'b0;
    if (!g.halted) begin
      if (g.privMode == PRIV_M) begin
        g.enM = g.mGie; // [RULE_01]
        g.enS = 1'b0; // [RULE_02]
      end else if (g.privMode == PRIV_S) begin
        g.enM = 1'b1; // [RULE_03]
        g.enS = g.sGie; // [RULE_01]
      end else begin
        g.enM = 1'b1; // [RULE_03]
        g.enS = 1'b1; // [RULE_03]
      end
    end
  end

  // Sampled on the core clock so a mode change and the enable it causes are seen together
  chk_gate_lower_off: assert property (@(posedge g.clk) g.privMode == PRIV_M |-> !g.enS) // [RULE_02]
    else $error("supervisor interrupts enabled in machine mode");
endmodule : irq_gate

/* File: hw/trap_priv_stack.sv */
// Privilege and interrupt-enable stack with double-trap detection
`timescale 1ns/1ns
// Behaviour
// [RULE_01] Same-mode interrupts follow that mode's global enable bit.
// [RULE_02] Interrupts for lower modes are always globally disabled.
// [RULE_03] Interrupts for higher modes are always globally enabled.
// [RULE_04] Machine prior mode holds two bits, supervisor prior mode one bit.
// [RULE_05] Trap entry stacks enable, clears it, records origin mode.
// [RULE_06] Return restores enable, mode; sets prior enable; prior mode to least mode.
// [RULE_07] Return to non-machine mode clears load-store privilege modify bit.
// [RULE_08] Prior mode fields hold only legal modes; absent owner reads zero.
// [RULE_09] With only user and machine, machine prior mode reads 00 or 11.
// [RULE_10] Machine trap-disable flag is one after reset.
// [RULE_11] Software setting trap-disable clears machine enable, even same write.
// [RULE_12] Software sets machine enable only when trap-disable is or becomes zero.
// [RULE_13] Machine trap sets trap-disable; already set means unexpected trap.
// [RULE_14] Resumable NMI is never unexpected and keeps trap-disable.
// [RULE_15] Trap in machine mode with NMI enable clear is unexpected.
// [RULE_16] Unexpected trap with NMI enabled goes to NMI handler, saving pc, cause.
// [RULE_17] Otherwise unexpected trap enters critical error, freezing all state.
// [RULE_18] Machine or supervisor return in machine mode clears trap-disable flags; supervisor ones only on return to user or virtual mode.
// [RULE_19] NMI return clears machine trap-disable only when leaving machine mode.
module trap_priv_stack
  import trap_stack_pkg::*;
#(
  parameter bit U_IMPL = 1'b1,
  parameter bit S_IMPL = 1'b1,
  parameter bit H_IMPL = 1'b0,
  parameter bit NMI_IMPL = 1'b1,
  parameter bit RV64 = 1'b1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DW-1:0] regRdata,
  // Trap and return events from the pipeline
  input wire logic trapValid,
  input wire logic trapToS,
  input wire logic trapNmi,
  input wire logic [DW-1:0] trapEpc,
  input wire logic [DW-1:0] trapCause,
  input wire logic retM,
  input wire logic retS,
  input wire logic retNmi,
  // Hart state towards the pipeline
  output logic [1:0] privMode,
  output logic virtMode,
  output logic lsPrivMod,
  output logic irqEnM,
  output logic irqEnS,
  output logic nmiEnable,
  output logic trapDone,
  output redir_e redirKind,
  // Platform
  output logic critError
);
  if (S_IMPL && !U_IMPL) begin : g_chk_s
    $error("supervisor mode requires user mode");
  end
  if (H_IMPL && !S_IMPL) begin : g_chk_h
    $error("virtualization requires supervisor mode");
  end

  typedef struct packed {
    hart_e hart;
    logic [1:0] priv;
    logic virt;
    logic mGie;
    logic sGie;
    logic mPrevIe;
    logic sPrevIe;
    logic [1:0] mPrevPriv;
    logic sPrevPriv;
    logic mPrevVirt;
    logic lsMod;
    logic mTrapOff;
    logic sTrapOff;
    logic vsTrapOff;
    logic nmiOn;
    logic [1:0] nmiPrevPriv;
    logic nmiPrevVirt;
    logic [DW-1:0] mEpc;
    logic [DW-1:0] mCause;
    logic [DW-1:0] nEpc;
    logic [DW-1:0] nCause;
    logic [DW-1:0] rdata;
    logic done;
    redir_e kind;
    logic enM;
    logic enS;
    logic nmiOk;
  } state_s;

  state_s r;
  state_s n;
  logic evRun;
  logic evNmi;
  logic evSTrap;
  logic evUnexp;
  logic evMNorm;
  logic evNmiRedir;
  logic evCrit;
  logic [1:0] newPriv;
  logic newVirt;
  logic wMtrap;

  irq_gate_if gi ();
  irq_gate u_gate (.g(gi.gate));
  assign gi.privMode = r.priv;
  assign gi.mGie = r.mGie;
  assign gi.sGie = r.sGie;
  assign gi.halted = (r.hart == HART_CRIT);
  assign gi.clk = clk;

  function automatic logic [1:0] leastMode();
    return U_IMPL ? PRIV_U : PRIV_M;
  endfunction : leastMode

  // Illegal codes fall back to machine mode so the field never holds reserved values
  function automatic logic [1:0] legalPrev(input logic [1:0] v);
    logic [1:0] res;
    res = PRIV_M;
    case (v)
      PRIV_S: res = S_IMPL ? PRIV_S : PRIV_M;
      PRIV_U: res = U_IMPL ? PRIV_U : PRIV_M;
      default: res = PRIV_M;
    endcase
    return res;
  endfunction : legalPrev

  function automatic logic [DW-1:0] readReg(input state_s s, input logic [AW-1:0] a);
    logic [DW-1:0] d;
    d = '0;
    case (a)
      OFS_STATUS: begin
        d[BIT_SGIE] = s.sGie;
        d[BIT_MGIE] = s.mGie;
        d[BIT_SPREV_IE] = s.sPrevIe;
        d[BIT_MPREV_IE] = s.mPrevIe;
        d[BIT_SPREV_PRIV] = s.sPrevPriv;
        d[BIT_MPREV_PRIV +: 2] = s.mPrevPriv;
        d[BIT_LS_PRIV] = s.lsMod;
        d[BIT_STRAP_OFF] = s.sTrapOff;
        if (RV64) begin
          d[BIT_MPREV_VIRT] = s.mPrevVirt;
          d[BIT_MTRAP_OFF] = s.mTrapOff;
        end
      end
      OFS_STATUSH: begin
        if (!RV64) begin
          d[BITH_MPREV_VIRT] = s.mPrevVirt;
          d[BITH_MTRAP_OFF] = s.mTrapOff;
        end
      end
      OFS_NMI_STATUS: begin
        d[BITN_NMI_ON] = s.nmiOn;
        d[BITN_PREV_VIRT] = s.nmiPrevVirt;
        d[BITN_PREV_PRIV +: 2] = s.nmiPrevPriv;
      end
      OFS_NMI_EPC: d = s.nEpc;
      OFS_NMI_CAUSE: d = s.nCause;
      OFS_M_EPC: d = s.mEpc;
      OFS_M_CAUSE: d = s.mCause;
      OFS_HART_STATE: begin
        d[BITS_PRIV +: 2] = s.priv;
        d[BITS_VIRT] = s.virt;
        d[BITS_CRIT] = (s.hart == HART_CRIT);
      end
      OFS_VS_STATUS: d[BIT_STRAP_OFF] = s.vsTrapOff;
      default: d = '0;
    endcase
    return d;
  endfunction : readReg

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.rdata = '0;
    n.enM = gi.enM;
    n.enS = gi.enS;
    evRun = (r.hart == HART_RUN);
    evNmi = 1'b0;
    evSTrap = 1'b0;
    evUnexp = 1'b0;
    evMNorm = 1'b0;
    evNmiRedir = 1'b0;
    evCrit = 1'b0;
    newPriv = PRIV_M;
    newVirt = 1'b0;
    wMtrap = RV64 ? regWdata[BIT_MTRAP_OFF] : r.mTrapOff;
    if (regRd) begin
      n.rdata = readReg(r, regAddr);
    end
    // Software writes; pipeline events below override them in the same cycle
    if (regWr && evRun) begin
      case (regAddr)
        OFS_STATUS: begin
          n.sGie = S_IMPL & regWdata[BIT_SGIE];
          n.sPrevIe = S_IMPL & regWdata[BIT_SPREV_IE];
          n.sPrevPriv = S_IMPL & regWdata[BIT_SPREV_PRIV]; // [RULE_08]
          n.mPrevIe = regWdata[BIT_MPREV_IE];
          n.mPrevPriv = legalPrev(regWdata[BIT_MPREV_PRIV +: 2]); // [RULE_08] [RULE_09]
          n.lsMod = U_IMPL & regWdata[BIT_LS_PRIV];
          n.sTrapOff = S_IMPL & regWdata[BIT_STRAP_OFF];
          if (RV64) begin
            n.mPrevVirt = H_IMPL & regWdata[BIT_MPREV_VIRT];
            n.mTrapOff = wMtrap;
          end
          n.mGie = regWdata[BIT_MGIE] & ~wMtrap; // [RULE_11] [RULE_12]
        end
        OFS_STATUSH: begin
          if (!RV64) begin
            n.mPrevVirt = H_IMPL & regWdata[BITH_MPREV_VIRT];
            n.mTrapOff = regWdata[BITH_MTRAP_OFF];
            if (regWdata[BITH_MTRAP_OFF]) begin
              n.mGie = 1'b0; // [RULE_11]
            end
          end
        end
        OFS_NMI_STATUS: begin
          // Software may set but never clear the NMI enable
          n.nmiOn = NMI_IMPL & (r.nmiOn | regWdata[BITN_NMI_ON]);
          n.nmiPrevPriv = legalPrev(regWdata[BITN_PREV_PRIV +: 2]); // [RULE_08]
          n.nmiPrevVirt = H_IMPL & regWdata[BITN_PREV_VIRT];
        end
        OFS_NMI_EPC: n.nEpc = regWdata;
        OFS_NMI_CAUSE: n.nCause = regWdata;
        OFS_M_EPC: n.mEpc = regWdata;
        OFS_M_CAUSE: n.mCause = regWdata;
        OFS_VS_STATUS: n.vsTrapOff = H_IMPL & regWdata[BIT_STRAP_OFF];
        default: n.rdata = n.rdata;
      endcase
    end
    if (trapValid && evRun) begin
      n.done = 1'b1;
      if (trapNmi && NMI_IMPL) begin
        evNmi = 1'b1; // [RULE_14]
      end else if (trapToS && S_IMPL && r.priv != PRIV_M) begin
        evSTrap = 1'b1;
      end else begin
        evUnexp = r.mTrapOff || (NMI_IMPL && r.priv == PRIV_M && !r.nmiOn); // [RULE_13] [RULE_15]
        evNmiRedir = evUnexp && NMI_IMPL && r.nmiOn; // [RULE_16]
        evCrit = evUnexp && !evNmiRedir; // [RULE_17]
        evMNorm = !evUnexp;
      end
      if (evNmi || evNmiRedir) begin
        n.nEpc = trapEpc; // [RULE_16]
        n.nCause = trapCause;
        n.nmiPrevPriv = evNmi ? r.priv : PRIV_M; // [RULE_16]
        n.nmiPrevVirt = evNmi & r.virt;
        n.nmiOn = 1'b0;
        n.priv = PRIV_M;
        n.virt = 1'b0;
        n.kind = REDIR_NMI;
      end else if (evSTrap) begin
        n.sPrevIe = r.sGie; // [RULE_05]
        n.sGie = 1'b0;
        n.sPrevPriv = r.priv[0]; // [RULE_04]
        n.priv = PRIV_S;
        n.virt = 1'b0;
        n.kind = REDIR_S;
      end else if (evMNorm) begin
        n.mPrevIe = r.mGie; // [RULE_05]
        n.mGie = 1'b0;
        n.mPrevPriv = r.priv; // [RULE_04]
        n.mPrevVirt = r.virt;
        n.mTrapOff = 1'b1; // [RULE_13]
        n.mEpc = trapEpc;
        n.mCause = trapCause;
        n.priv = PRIV_M;
        n.virt = 1'b0;
        n.kind = REDIR_M;
      end else begin
        // Critical error: architectural state and pc are left as they were,
        // so a register write in the same cycle is dropped as well
        n = r;
        n.hart = HART_CRIT; // [RULE_17]
        n.done = 1'b0;
        n.rdata = regRd ? readReg(r, regAddr) : '0;
        n.enM = 1'b0; // [RULE_17]
        n.enS = 1'b0;
      end
    end else if (retM && evRun) begin
      newPriv = r.mPrevPriv;
      newVirt = (r.mPrevPriv != PRIV_M) & r.mPrevVirt;
      n.mGie = r.mPrevIe; // [RULE_06]
      n.mPrevIe = 1'b1;
      n.mPrevPriv = leastMode();
      n.mPrevVirt = 1'b0;
    end else if (retS && evRun && S_IMPL) begin
      newPriv = {1'b0, r.sPrevPriv};
      newVirt = r.virt;
      n.sGie = r.sPrevIe; // [RULE_06]
      n.sPrevIe = 1'b1;
      n.sPrevPriv = 1'b0;
    end else if (retNmi && evRun && NMI_IMPL) begin
      newPriv = r.nmiPrevPriv;
      newVirt = (r.nmiPrevPriv != PRIV_M) & r.nmiPrevVirt;
      n.nmiOn = 1'b1;
      if (newPriv != PRIV_M) begin
        n.mTrapOff = 1'b0; // [RULE_19]
      end
    end
    if (evRun && !trapValid && (retM || (retS && S_IMPL) || (retNmi && NMI_IMPL))) begin
      n.priv = newPriv; // [RULE_06]
      n.virt = newVirt;
      n.done = 1'b1;
      n.kind = REDIR_RET;
      if (newPriv != PRIV_M) begin
        n.lsMod = 1'b0; // [RULE_07]
      end
      if ((retM || retS) && r.priv == PRIV_M) begin
        n.mTrapOff = 1'b0; // [RULE_18]
      end
      if ((retNmi || r.priv == PRIV_M) && (newPriv == PRIV_U || newVirt)) begin
        n.sTrapOff = 1'b0; // [RULE_18] [RULE_19]
        if (newVirt && newPriv == PRIV_U) begin
          n.vsTrapOff = 1'b0;
        end
      end
    end
    // Follows the next state so a cleared NMI enable is never shown for an extra cycle
    n.nmiOk = n.nmiOn && (n.hart == HART_RUN); // [RULE_17]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.priv <= PRIV_M;
      r.mPrevPriv <= leastMode();
      r.mTrapOff <= RST_MTRAP_OFF; // [RULE_10]
      r.nmiOn <= RST_NMI_ON;
      r.nmiPrevPriv <= PRIV_M;
    end else begin
      r <= n;
    end
  end

  assign regRdata = r.rdata;
  assign privMode = r.priv;
  assign virtMode = r.virt;
  assign lsPrivMod = r.lsMod;
  assign irqEnM = r.enM;
  assign irqEnS = r.enS;
  assign nmiEnable = r.nmiOk;
  assign trapDone = r.done;
  assign redirKind = r.kind;
  assign critError = (r.hart == HART_CRIT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_trap_off: assert property ($rose(rst_n) |-> r.mTrapOff && !r.mGie) // [RULE_10]
    else $error("trap-disable not set after reset");
  chk_same_mode_en: assert property (r.priv == PRIV_M && evRun && !evCrit
    |=> irqEnM == $past(r.mGie)) // [RULE_01]
    else $error("machine enable not followed in machine mode");
  chk_lower_mode_off: assert property (r.priv == PRIV_M |=> !irqEnS) // [RULE_02]
    else $error("lower mode interrupts enabled");
  chk_higher_mode_on: assert property (r.priv != PRIV_M && evRun && !evCrit |=> irqEnM) // [RULE_03]
    else $error("higher mode interrupts disabled");
  chk_off_blocks_en: assert property (r.mTrapOff |-> !r.mGie) // [RULE_11]
    else $error("machine enable set while trap-disable set");
  chk_mtrap_stack: assert property (evMNorm |=> r.mPrevIe == $past(r.mGie) && !r.mGie
    && r.mPrevPriv == $past(r.priv) && r.mTrapOff && trapDone && redirKind == REDIR_M) // [RULE_13]
    else $error("machine trap entry stack wrong");
  chk_machine_trap_return_instr_restore: assert property (retM && evRun && !trapValid |=> r.mGie == $past(r.mPrevIe)
    && r.mPrevIe && r.mPrevPriv == leastMode() && !r.mTrapOff) // [RULE_06]
    else $error("machine return restore wrong");
  chk_ret_ls_clear: assert property (retM && evRun && !trapValid && r.mPrevPriv != PRIV_M
    |=> !lsPrivMod) // [RULE_07]
    else $error("load-store privilege bit not cleared");
  chk_prev_legal: assert property (r.mPrevPriv != PRIV_RSV && (S_IMPL || r.mPrevPriv != PRIV_S)) // [RULE_09]
    else $error("machine prior mode illegal");
  chk_nmi_keep_off: assert property (evNmi |=> r.mTrapOff == $past(r.mTrapOff) && !r.nmiOn) // [RULE_14]
    else $error("resumable NMI changed trap-disable");
  chk_unexp_redir: assert property (evNmiRedir |=> r.nEpc == $past(trapEpc)
    && r.nmiPrevPriv == PRIV_M && !nmiEnable && redirKind == REDIR_NMI) // [RULE_16]
    else $error("unexpected trap not sent to NMI handler");
  chk_crit_freeze: assert property (evCrit |=> critError && !trapDone && !irqEnM && !nmiEnable
    && r.mEpc == $past(r.mEpc) && r.priv == $past(r.priv)) // [RULE_17]
    else $error("critical error state wrong");
  chk_nmiret_stay: assert property (retNmi && evRun && !trapValid && NMI_IMPL
    && r.nmiPrevPriv == PRIV_M |=> r.mTrapOff == $past(r.mTrapOff)) // [RULE_19]
    else $error("NMI return to machine changed trap-disable");

  cov_mtrap: cover property (evMNorm ##[1:20] retM);
  cov_nmi_redir: cover property (evNmiRedir);
  cov_crit: cover property (evCrit);
  cov_strap: cover property (evSTrap ##[1:20] retS);
endmodule : trap_priv_stack

/* File: dv/pipe_model.sv */
// Pipeline and platform stand-in: issues trap and return events, watches the error line
`timescale 1ns/1ns
module pipe_model
  import trap_stack_pkg::*;
#(
  parameter logic [DW-1:0] EPC = 64'h0000_0000_8000_0ABC,
  parameter logic [DW-1:0] CAUSE = 64'h0000_0000_0000_0005
)
(
  // Clock
  input wire logic clk,
  // Events towards the block
  output logic trapValid,
  output logic trapToS,
  output logic trapNmi,
  output logic [DW-1:0] trapEpc,
  output logic [DW-1:0] trapCause,
  output logic retM,
  output logic retS,
  output logic retNmi,
  // Platform side
  input wire logic critError
);
  logic critSeen;

  initial begin
    trapValid = 1'b0;
    trapToS = 1'b0;
    trapNmi = 1'b0;
    retM = 1'b0;
    retS = 1'b0;
    retNmi = 1'b0;
    trapEpc = ~EPC;
    trapCause = ~CAUSE;
    critSeen = 1'b0;
  end

  // The platform only latches the error; the bench checks the latch and ends the test without a reset
  always @(posedge clk) begin
    if (critError === 1'b1) begin
      critSeen <= 1'b1;
    end
  end

  // Kind: 1 trap, 2 delegated trap, 3 resumable NMI, 4/5/6 returns
  task fire(input logic [2:0] kind);
    @(posedge clk);
    trapValid <= (kind inside {3'h1, 3'h2, 3'h3});
    trapToS <= (kind == 3'h2);
    trapNmi <= (kind == 3'h3);
    trapEpc <= EPC;
    trapCause <= CAUSE;
    retM <= (kind == 3'h4);
    retS <= (kind == 3'h5);
    retNmi <= (kind == 3'h6);
    @(posedge clk);
    trapValid <= 1'b0;
    trapToS <= 1'b0;
    trapNmi <= 1'b0;
    retM <= 1'b0;
    retS <= 1'b0;
    retNmi <= 1'b0;
    // Qualifiers are not held after the event, so show a changed value
    trapEpc <= ~EPC;
    trapCause <= ~CAUSE;
  endtask : fire
endmodule : pipe_model

/* File: dv/trap_priv_stack_bench.sv */
// Self-checking bench for the trap privilege stack
`timescale 1ns/1ns
module trap_priv_stack_bench
  import trap_stack_pkg::*;
;
  localparam logic [DW-1:0] SMASK = 64'h0000_0400_0102_19AA;
  localparam logic [DW-1:0] TRAP_OFF = 64'h0000_0400_0000_0000;
  typedef struct {
    logic [2:0] op;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [1:0] priv;
    logic [DW-1:0] st;
    logic [1:0] en;
    redir_e rk;
  } row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] regAddr = 8'h00;
  logic [DW-1:0] regWdata = 64'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DW-1:0] regRdata;
  logic trapValid, trapToS, trapNmi, retM, retS, retNmi;
  logic [DW-1:0] trapEpc, trapCause;
  logic [1:0] privMode;
  logic lsPrivMod, irqEnM, irqEnS, nmiEnable, trapDone, critError;
  logic virtMode;
  redir_e redirKind;
  int err_count = 0;
  int compares = 0;
  row_s rows [15];
  logic [DW-1:0] v;

  always #25 clk = ~clk;

  trap_priv_stack u_trap_priv_stack (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .trapValid(trapValid), .trapToS(trapToS), .trapNmi(trapNmi), .trapEpc(trapEpc),
    .trapCause(trapCause), .retM(retM), .retS(retS), .retNmi(retNmi),
    .privMode(privMode), .virtMode(virtMode), .lsPrivMod(lsPrivMod), .irqEnM(irqEnM),
    .irqEnS(irqEnS), .nmiEnable(nmiEnable), .trapDone(trapDone),
    .redirKind(redirKind), .critError(critError));

  pipe_model u_pipe_model (.clk(clk), .trapValid(trapValid), .trapToS(trapToS),
    .trapNmi(trapNmi), .trapEpc(trapEpc), .trapCause(trapCause), .retM(retM),
    .retS(retS), .retNmi(retNmi), .critError(critError));

  task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task reset_dut;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask : reset_dut

  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask : rd

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("Watchdog expired");
    stop_test();
  end

  initial begin
    // Op 0 is a register write, others are event kinds of the pipeline model
    rows = '{
      '{3'h0, OFS_STATUS, 64'h0000_0400_0000_0008, 2'h3, TRAP_OFF, 2'h0, REDIR_M},
      '{3'h0, OFS_STATUS, 64'h0000_0000_0000_0888, 2'h3, 64'h888, 2'h2, REDIR_M},
      '{3'h4, OFS_STATUS, 64'h0, 2'h1, 64'h88, 2'h2, REDIR_RET},
      '{3'h1, OFS_STATUS, 64'h0, 2'h3, 64'h0000_0400_0000_0880, 2'h0, REDIR_M},
      '{3'h0, OFS_STATUS, 64'h0000_0400_0000_1080, 2'h3, 64'h0000_0400_0000_1880, 2'h0, REDIR_M},
      '{3'h4, OFS_STATUS, 64'h0, 2'h3, 64'h88, 2'h2, REDIR_RET},
      '{3'h0, OFS_NMI_STATUS, 64'h8, 2'h3, 64'h88, 2'h2, REDIR_M},
      '{3'h1, OFS_STATUS, 64'h0, 2'h3, 64'h0000_0400_0000_1880, 2'h0, REDIR_M},
      '{3'h1, OFS_STATUS, 64'h0, 2'h3, 64'h0000_0400_0000_1880, 2'h0, REDIR_NMI},
      '{3'h6, OFS_STATUS, 64'h0, 2'h3, 64'h0000_0400_0000_1880, 2'h0, REDIR_RET},
      '{3'h0, OFS_STATUS, 64'h0000_0000_0102_0122, 2'h3, 64'h0102_0122, 2'h0, REDIR_M},
      '{3'h4, OFS_STATUS, 64'h0, 2'h0, 64'h1A2, 2'h3, REDIR_RET},
      '{3'h2, OFS_STATUS, 64'h0, 2'h1, 64'hA0, 2'h2, REDIR_S},
      '{3'h5, OFS_STATUS, 64'h0, 2'h0, 64'hA2, 2'h3, REDIR_RET},
      '{3'h3, OFS_STATUS, 64'h0, 2'h3, 64'hA2, 2'h0, REDIR_NMI}};
    reset_dut();
    rd(OFS_STATUS, v);
    chk(v & TRAP_OFF, TRAP_OFF);
    chk(privMode, PRIV_M);
    $display("Test reset done");
    foreach (rows[i]) begin
      if (rows[i].op == 3'h0) begin
        wr(rows[i].addr, rows[i].data);
      end else begin
        u_pipe_model.fire(rows[i].op);
        @(negedge clk);
        chk(trapDone, 1'b1);
        chk(redirKind, rows[i].rk);
      end
      rd(OFS_STATUS, v);
      chk(v & SMASK, rows[i].st);
      chk(privMode, rows[i].priv);
      chk({irqEnM, irqEnS}, rows[i].en);
      $display("Test row %0d done", i);
    end
    // Hart state word is read-only; unmapped places read zero
    wr(OFS_HART_STATE, 64'h0);
    rd(OFS_HART_STATE, v);
    chk(v & 64'hF, 64'h3);
    chk(virtMode, 1'b0);
    chk(lsPrivMod, 1'b0);
    wr(8'h48, 64'hFF);
    rd(8'h48, v);
    chk(v, 64'h0);
    $display("Test register map done");
    // Straight after reset the flag is set, so every trap other than a resumable NMI is unexpected
    reset_dut();
    wr(OFS_NMI_STATUS, 64'h8);
    u_pipe_model.fire(3'h1);
    @(negedge clk);
    chk(redirKind, REDIR_NMI);
    chk(critError, 1'b0);
    rd(OFS_NMI_EPC, v);
    chk(v, u_pipe_model.EPC);
    rd(OFS_NMI_CAUSE, v);
    chk(v, u_pipe_model.CAUSE);
    rd(OFS_M_EPC, v);
    chk(v, 64'h0);
    rd(OFS_NMI_STATUS, v);
    chk(v & 64'h1808, 64'h1800);
    u_pipe_model.fire(3'h1);
    @(negedge clk);
    chk(critError, 1'b1);
    chk(trapDone, 1'b0);
    wr(OFS_STATUS, 64'h8);
    u_pipe_model.fire(3'h4);
    rd(OFS_STATUS, v);
    chk(v & (TRAP_OFF | 64'h8), TRAP_OFF);
    chk({privMode, irqEnM, irqEnS, nmiEnable}, 5'h18);
    chk(u_pipe_model.critSeen, 1'b1);
    $display("Test critical error done");
    stop_test();
  end
endmodule : trap_priv_stack_bench
